// ---- shared/dma_setup_consts.vh ----
// Purpose: constants for the DMA channel transfer setup block
// Assumes: register port with byte addresses, 32-bit data
// Notes:   offsets are byte addresses of aligned words
`ifndef DMA_SETUP_CONSTS_VH
`define DMA_SETUP_CONSTS_VH

// Register byte offsets
`define OFF_SETUP      8'h00
`define OFF_SRC_ADDR   8'h04
`define OFF_DST_ADDR   8'h08
`define OFF_CONTROL    8'h0C
`define OFF_STATUS     8'h10
`define OFF_IRQ_MASK   8'h14
`define OFF_NEXT_SETUP 8'h18
`define OFF_NEXT_SRC   8'h1C
`define OFF_NEXT_DST   8'h20

// Setup word fields
`define F_VALID     0
`define F_RELOAD    1
`define F_SWTRIG    2
`define F_CLRTRIG   3
`define F_FLAG_A    4
`define F_FLAG_B    5
`define F_WIDTH_LO  8
`define F_WIDTH_HI  9
`define F_SSTEP_LO  12
`define F_SSTEP_HI  13
`define F_DSTEP_LO  14
`define F_DSTEP_HI  15
`define F_COUNT_LO  16
`define F_COUNT_HI  25

// Control register fields
`define C_PACING    0
`define C_TRIG      1

// Status / mask bits
`define S_FLAG_A    0
`define S_FLAG_B    1
`define S_DONE      2
`define S_BUS_ERR   3

// Width encodings
`define W_8BIT      2'h0
`define W_16BIT     2'h1
`define W_32BIT     2'h2

// Reset values
`define SETUP_RESET 32'h00000000
`define ZERO32      32'h00000000

// Writable setup bits: unused ranges are not stored and read as zero
`define SETUP_MASK  32'h03FFF33F

`endif

// ---- hw/dma_channel_transfer_setup.v ----
// Purpose: one DMA channel: setup word, address stepping, count-down, flags
// Assumes: one system clock, bus slaves answer in one cycle unless stalled
// Notes:   a transfer is one source read then one destination write
//          writes to engine-owned registers while busy are dropped
// How it works
// - With raise_flag_b_on_done set, flag B is set when the descriptor ends; clear means no effect.
// - Flags A and B are raised by identical logic and differ only in software meaning.
// - The width field picks 8, 16 or 32 bit size for every source read and destination write.
// - After each transfer the source address steps by 0, 1, 2 or 4 widths per source_step.
// - After each transfer the destination address steps by 0, 1, 2 or 4 widths per dest_step.
// - The ten-bit count holds transfers minus one, so 0 gives one and 0x3FF gives 1024.
// - Bytes moved per descriptor equal count plus one times the width in bytes.
// - The count field counts down while running, so a read shows what is left.
// - On an exhausted descriptor with reload set, the next descriptor is loaded.
// - A triggered channel is paced by peripheral requests when pacing is on, else runs free.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dma_setup_consts.vh"

module dma_channel_transfer_setup (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        periph_req,
  output wire        rd_req,
  output reg  [31:0] rd_addr,
  output reg  [1:0]  rd_size,
  input  wire        rd_ack,
  input  wire [31:0] rd_data,
  output wire        wr_req,
  output reg  [31:0] wr_addr,
  output reg  [1:0]  wr_size,
  output reg  [31:0] wr_data,
  input  wire        wr_ack,
  output wire        busy,
  output wire        irq
);

  // Sequencer states; one transfer is a read then a write
  // Width code 3 is not refused here; software keeps it out
  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_WRITE = 2'h2;

  // Live descriptor
  reg  [31:0] setup_reg;
  reg  [31:0] src_reg;
  reg  [31:0] dst_reg;

  // Staged descriptor for reload
  reg  [31:0] next_setup_reg;
  reg  [31:0] next_src_reg;
  reg  [31:0] next_dst_reg;

  // Control, status and sequencer state
  reg         pacing_reg;
  reg         trig_reg;
  reg  [3:0]  status_reg;
  reg  [3:0]  mask_reg;
  reg  [1:0]  state_reg;

  // Setup fields, decoded once
  wire [1:0]  width     = setup_reg[`F_WIDTH_HI:`F_WIDTH_LO];
  wire [1:0]  src_step  = setup_reg[`F_SSTEP_HI:`F_SSTEP_LO];
  wire [1:0]  dst_step  = setup_reg[`F_DSTEP_HI:`F_DSTEP_LO];
  wire [9:0]  count     = setup_reg[`F_COUNT_HI:`F_COUNT_LO];
  wire        valid     = setup_reg[`F_VALID];

  // Address step in bytes: width bytes times 0, 1, 2 or 4
  // Shifts keep each step a power of two; no multiplier needed
  function [31:0] step_bytes;
    input [1:0] w;
    input [1:0] s;
    reg   [31:0] unit;
    begin
      case (w)
        `W_8BIT:  unit = 32'h00000001;
        `W_16BIT: unit = 32'h00000002;
        default:  unit = 32'h00000004; // Reserved code 3 treated as 32-bit
      endcase
      case (s)
        2'h0:    step_bytes = 32'h00000000;
        2'h1:    step_bytes = unit;
        2'h2:    step_bytes = {unit[30:0], 1'b0};
        default: step_bytes = {unit[29:0], 2'b00};
      endcase
    end
  endfunction

  // Pacing gate: free-running unless request pacing is enabled
  // The request is looked at only when a transfer starts;
  // a request that drops mid-transfer does not stall it
  wire go_ok      = !pacing_reg || periph_req;
  wire start      = (state_reg == ST_IDLE) && trig_reg && valid && go_ok;
  wire xfer_done  = (state_reg == ST_WRITE) && wr_ack;
  wire last       = xfer_done && (count == 10'h000);
  wire reload_now = last && setup_reg[`F_RELOAD];

  // Handshakes straight from the state; data outputs are registered
  assign rd_req = (state_reg == ST_READ);
  assign wr_req = (state_reg == ST_WRITE);
  assign busy   = (state_reg != ST_IDLE);
  assign irq    = |(status_reg & mask_reg);

  // Offset match; shared by every write select and the status read
  function reg_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      reg_hit = (addr == off);
    end
  endfunction

  // Write selects, one per register except status; unmapped offsets match none
  wire wr_setup  = reg_wr && reg_hit(reg_addr, `OFF_SETUP);
  wire wr_src    = reg_wr && reg_hit(reg_addr, `OFF_SRC_ADDR);
  wire wr_dst    = reg_wr && reg_hit(reg_addr, `OFF_DST_ADDR);
  wire wr_ctrl   = reg_wr && reg_hit(reg_addr, `OFF_CONTROL);
  wire wr_mask   = reg_wr && reg_hit(reg_addr, `OFF_IRQ_MASK);
  wire wr_nsetup = reg_wr && reg_hit(reg_addr, `OFF_NEXT_SETUP);
  wire wr_nsrc   = reg_wr && reg_hit(reg_addr, `OFF_NEXT_SRC);
  wire wr_ndst   = reg_wr && reg_hit(reg_addr, `OFF_NEXT_DST);

  // Status read clears the sticky bits in the same cycle
  wire rd_stat   = reg_rd && reg_hit(reg_addr, `OFF_STATUS);

  // Engine-owned registers: a write while busy is dropped and flagged
  wire wr_locked = busy && (wr_setup || wr_src || wr_dst);

  // Transfer sequencer: one read, one write, then step and count
  // Requests stand until acknowledged; a stuck slave hangs the channel
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      rd_addr   <= `ZERO32;
      rd_size   <= 2'h0;
      wr_addr   <= `ZERO32;
      wr_size   <= 2'h0;
      wr_data   <= `ZERO32;
    end else begin
      case (state_reg)
        // Read address and size latched at start; setup is locked while busy
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_READ;
            rd_addr   <= src_reg;
            rd_size   <= width;
          end
        end
        // Read data goes straight to the write register
        ST_READ: begin
          if (rd_ack) begin
            state_reg <= ST_WRITE;
            wr_data   <= rd_data;
            wr_addr   <= dst_reg;
            wr_size   <= width;
          end
        end
        // Back to idle for one cycle before the next start
        ST_WRITE: begin
          if (wr_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Next descriptor, staged for reload; writable while busy
  // Reload copies all three words at one edge
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      next_setup_reg <= `SETUP_RESET;
      next_src_reg   <= `ZERO32;
      next_dst_reg   <= `ZERO32;
    end else begin
      if (wr_nsetup)
        next_setup_reg <= reg_wdata & `SETUP_MASK;
      if (wr_nsrc)
        next_src_reg <= reg_wdata;
      if (wr_ndst)
        next_dst_reg <= reg_wdata;
    end
  end

  // Source and destination pointers: step after each transfer
  // Reserved width 3 steps as 32-bit; software must never use it
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_reg <= `ZERO32;
      dst_reg <= `ZERO32;
    end else if (reload_now) begin
      src_reg <= next_src_reg;
      dst_reg <= next_dst_reg;
    end else if (xfer_done) begin
      src_reg <= src_reg + step_bytes(width, src_step);
      dst_reg <= dst_reg + step_bytes(width, dst_step);
    end else if (!busy) begin
      if (wr_src)
        src_reg <= reg_wdata;
      if (wr_dst)
        dst_reg <= reg_wdata;
    end
  end

  // Setup word; the engine owns it while a transfer runs
  // Count decrements in place, so a read shows transfers left
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_reg <= `SETUP_RESET;
    end else if (reload_now) begin
      setup_reg <= next_setup_reg;
    end else if (last) begin
      setup_reg[`F_VALID] <= 1'b0;
    end else if (xfer_done) begin
      setup_reg[`F_COUNT_HI:`F_COUNT_LO] <= count - 10'h001;
    end else if (wr_setup && !busy) begin
      setup_reg <= reg_wdata & `SETUP_MASK;
    end
  end

  // Trigger and pacing control
  // Trigger drops at the end unless reloading without clear-trigger
  // A setup write with the software-trigger bit starts the channel
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_reg   <= 1'b0;
      pacing_reg <= 1'b0;
    end else begin
      if (wr_ctrl)
        pacing_reg <= reg_wdata[`C_PACING];
      if (last && (setup_reg[`F_CLRTRIG] || !setup_reg[`F_RELOAD]))
        trig_reg <= 1'b0;
      else if (wr_setup && !busy && reg_wdata[`F_SWTRIG])
        trig_reg <= 1'b1;
      else if (wr_ctrl)
        trig_reg <= reg_wdata[`C_TRIG];
    end
  end

  // Events: A, B and done raised at the end of a descriptor, bit 3 on a dropped write; A and B share one path
  // Bit 3 flags a dropped write, never a bus fault
  wire [3:0] events;
  wire [3:0] status_next;
  assign events[`S_FLAG_A]  = last && setup_reg[`F_FLAG_A];
  assign events[`S_FLAG_B]  = last && setup_reg[`F_FLAG_B];
  assign events[`S_DONE]    = last;
  assign events[`S_BUS_ERR] = wr_locked; // Write dropped while running

  // Sticky bits; an event in the reading cycle survives the clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sticky
      assign status_next[gi] = events[gi] | (status_reg[gi] & ~rd_stat);
    end
  endgenerate

  // Status and mask registers; mask bits line up with status bits
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= 4'h0;
      mask_reg   <= 4'h0;
    end else begin
      status_reg <= status_next;
      if (wr_mask)
        mask_reg <= reg_wdata[3:0];
    end
  end

  // Readback mux; unmapped offsets return zero
  // Control bit 3 shows busy, bit 2 reads zero
  reg  [31:0] rd_mux;
  always @* begin
    rd_mux = `ZERO32;
    case (reg_addr)
      `OFF_SETUP:      rd_mux = setup_reg;
      `OFF_SRC_ADDR:   rd_mux = src_reg;
      `OFF_DST_ADDR:   rd_mux = dst_reg;
      `OFF_CONTROL:    rd_mux = {28'h0000000, busy, 1'b0, trig_reg, pacing_reg};
      `OFF_STATUS:     rd_mux = {28'h0000000, status_reg};
      `OFF_IRQ_MASK:   rd_mux = {28'h0000000, mask_reg};
      `OFF_NEXT_SETUP: rd_mux = next_setup_reg;
      `OFF_NEXT_SRC:   rd_mux = next_src_reg;
      `OFF_NEXT_DST:   rd_mux = next_dst_reg;
      default:         rd_mux = `ZERO32;
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `ZERO32;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= `ZERO32;
    end
  end

endmodule

// ---- tb/dma_setup_props.sv ----
// Purpose: port assertions for the DMA channel
// Assumes: one clock, async active-low reset
// Notes:   bound to the design top
`timescale 1ns/1ps
module dma_setup_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic [1:0]  rd_size,
  input wire logic        rd_ack,
  input wire logic [31:0] rd_data,
  input wire logic        wr_req,
  input wire logic [1:0]  wr_size,
  input wire logic [31:0] wr_data,
  input wire logic        wr_ack,
  input wire logic        busy,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Requests hold until answered
  property p_rd_hold; rd_req && !rd_ack |=> rd_req && $stable(rd_addr); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request moved");
  property p_wr_hold; wr_req && !wr_ack |=> wr_req && $stable(wr_data); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request moved");
  // One read datum feeds one write of the same size
  property p_size; rd_req && rd_ack |=> wr_req && wr_size == $past(rd_size); endproperty
  a_size: assert property (p_size) else $error("write size differs");
  property p_data; rd_req && rd_ack |=> wr_data == $past(rd_data); endproperty
  a_data: assert property (p_data) else $error("write data differs");
  property p_excl; !(rd_req && wr_req); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_gap; wr_req && wr_ack |=> !(rd_req || wr_req); endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after write");
  property p_busy; rd_req || wr_req |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy low in transfer");
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h00000000; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  c_wr: cover property (wr_req && wr_ack);
  c_irq: cover property (irq);
  c_back: cover property (wr_ack ##2 rd_req);
endmodule
bind dma_channel_transfer_setup dma_setup_props u_props (.ref_clk, .arst_n, .reg_rd,
  .reg_rdata, .rd_req, .rd_addr, .rd_size, .rd_ack, .rd_data, .wr_req, .wr_size,
  .wr_data, .wr_ack, .busy, .irq);

// ---- tb/sys_bus_model.sv ----
// Purpose: memory on the system bus
// Assumes: requests held until acknowledged
// Notes:   read data is the address scrambled
`timescale 1ns/1ps
module sys_bus_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  output logic             rd_ack,
  output logic [31:0]      rd_data,
  input  wire logic        wr_req,
  output logic             wr_ack,
  input  wire logic [1:0]  wait_cycles
);
  logic [1:0]  cnt;
  logic [31:0] junk;
  // Ack after a wait; data line churns when not answering
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {rd_ack, wr_ack, cnt, junk, rd_data} <= 'h0;
    end else begin
      junk <= junk + 32'h9E3779B9;
      rd_ack <= 1'b0;
      wr_ack <= 1'b0;
      rd_data <= junk;
      if ((rd_req && !rd_ack) || (wr_req && !wr_ack)) begin
        cnt <= (cnt == wait_cycles) ? 2'h0 : cnt + 2'h1;
        if (cnt == wait_cycles) begin
          rd_ack <= rd_req;
          wr_ack <= wr_req && !rd_req;
          rd_data <= rd_addr ^ 32'h5A5A0000;
        end
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the DMA channel
// Assumes: bus model answers after a random wait
// Notes:   expected results queued by the driver
`timescale 1ns/1ps
`include "dma_setup_consts.vh"
module tb_top;
  reg         ref_clk, arst_n, reg_wr, reg_rd, periph_req, rd_seen;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata, src, dst, cfg, fl, msk;
  reg  [31:0] nsrc, ndst, ncfg, st;
  reg  [1:0]  wait_cycles, w, ss, ds;
  wire [31:0] reg_rdata, rd_addr, rd_data, wr_addr, wr_data;
  wire [1:0]  rd_size, wr_size;
  wire        rd_req, rd_ack, wr_req, wr_ack, busy, irq;
  integer     num_errors, total_checks, i, k, n;
  reg  [31:0] qg[$];
  reg  [33:0] qr[$];
  reg  [65:0] qw[$];
  dma_channel_transfer_setup DUT (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .periph_req, .rd_req, .rd_addr, .rd_size, .rd_ack, .rd_data,
    .wr_req, .wr_addr, .wr_size, .wr_data, .wr_ack, .busy, .irq);
  sys_bus_model mem (.ref_clk, .arst_n, .rd_req, .rd_addr, .rd_ack, .rd_data, .wr_req,
    .wr_ack, .wait_cycles);
  task check(input [65:0] seen, input [65:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd} <= 2'h2;
    @(posedge ref_clk);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    qg.push_back(e);
    reg_addr <= a;
    {reg_wr, reg_rd} <= 2'h1;
    @(posedge ref_clk);
  endtask
  function [31:0] step_of(input [1:0] s);
    step_of = (s == 2'h0) ? 32'h0 : (32'h1 << w) << (s - 2'h1);
  endfunction
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Random pacing and bus waits
  always @(posedge ref_clk) {periph_req, wait_cycles} <= 3'($urandom);
  // Compare each answer with the oldest note
  always @(posedge ref_clk) begin
    if (rd_seen) check(reg_rdata, qg.pop_front(), "reg_rdata");
    if (rd_req && rd_ack) check({rd_addr, rd_size}, qr.pop_front(), "read");
    if (wr_req && wr_ack) check({wr_addr, wr_size, wr_data}, qw.pop_front(), "write");
    rd_seen <= reg_rd;
  end
  initial begin
    n = $urandom(48565);
    {arst_n, reg_wr, reg_rd, periph_req, reg_addr, reg_wdata, wait_cycles, rd_seen} = 'h0;
    {num_errors, total_checks} = 'h0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(`OFF_SETUP, `SETUP_RESET);
    rd(8'h24, `ZERO32);
    // Widths, steps and counts incl. the longest descriptor
    for (i = 0; i < 5; i = i + 1) begin
      w = 2'(i % 3);
      ss = 2'($urandom);
      ds = 2'($urandom);
      n = (i == 3) ? 1023 : i;
      fl = 32'h10 << (i % 2);
      msk = $urandom & 32'h3;
      src = $urandom & 32'h000FFF00;
      dst = $urandom & 32'h000FFF00;
      cfg = fl | (32'(w) << 8) | (32'(ss) << 12) | (32'(ds) << 14) | (32'(n) << 16) | 32'h1;
      ncfg = 32'h20 | (32'(w) << 8) | (32'(ss) << 12) | (32'(ds) << 14) | 32'h10001;
      if (i == 4) cfg = cfg | 32'h2;
      nsrc = src ^ 32'h00100000;
      ndst = dst ^ 32'h00100000;
      st = (fl >> 4) | 32'h4 | ((i == 4) ? 32'h2 : 32'h0);
      for (k = 0; k <= n; k = k + 1) begin
        qr.push_back({src + k * step_of(ss), w});
        qw.push_back({dst + k * step_of(ds), w, (src + k * step_of(ss)) ^ 32'h5A5A0000});
      end
      for (k = 0; (i == 4) && (k < 2); k = k + 1) begin
        qr.push_back({nsrc + k * step_of(ss), w});
        qw.push_back({ndst + k * step_of(ds), w, (nsrc + k * step_of(ss)) ^ 32'h5A5A0000});
      end
      wr(`OFF_NEXT_SRC, nsrc);
      wr(`OFF_NEXT_DST, ndst);
      wr(`OFF_NEXT_SETUP, ncfg);
      wr(`OFF_SRC_ADDR, src);
      wr(`OFF_DST_ADDR, dst);
      wr(`OFF_IRQ_MASK, msk);
      wr(`OFF_SETUP, cfg);
      wr(`OFF_CONTROL, {30'h0, 1'b1, i[0]});
      {reg_wr, reg_rd} <= 2'h0;
      for (k = 0; qw.size() > 0; k = k + 1) begin
        if (k > 30000) begin
          num_errors = num_errors + 1;
          give_verdict;
        end
        @(posedge ref_clk);
      end
      repeat (2) @(posedge ref_clk);
      check(irq, |(msk & st), "irq");
      check(busy, 1'b0, "busy");
      rd(`OFF_STATUS, st);
      rd(`OFF_STATUS, `ZERO32);
      rd(`OFF_SETUP, ((i == 4) ? ncfg : cfg) & 32'hFC00FFFE);
      {reg_wr, reg_rd} <= 2'h0;
      repeat (2) @(posedge ref_clk);
      check(irq, 1'b0, "irq");
    end
    give_verdict;
  end
endmodule
